// *** design/tefc_ctrl.sv ***
// Operation
// RULE1: writing one to reset request clears queue; hardware clears bit when done
// RULE2: software polls reset request until zero before using the queue
// RULE3: tail advance moves tail by exactly one message, then self-clears
// RULE4: timestamp enable one makes every stored element carry a timestamp
// RULE5: timestamp enable writable only in configuration operating mode
// RULE6: overflow raises interrupt only while overflow enable is one
// RULE7: full condition raises interrupt only while full enable is one
// RULE8: unimplemented control bits read zero; implemented bits reset to zero
// RULE9: bits one and zero gate half-full and not-empty interrupts
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tefc_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic queue_overflow,
	input wire logic queue_full,
	input wire logic queue_half_full,
	input wire logic queue_not_empty,
	output logic queue_clear,
	output logic tail_step,
	output logic event_timestamp_enable,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	logic [15:0] ctrl;
	logic [2:0] controller_operating_mode;
	logic [3:0] stat;
	logic [3:0] mask;
	logic [3:0] rst_cnt;
	logic [3:0] evt_level;
	logic [3:0] evt_rise;
	logic [3:0] evt_gate;
	logic [3:0] next_stat;
	logic [31:0] next_prdata;
	// one register per control concern, joined into ctrl below
	logic [3:0] irq_enable;
	logic ts_enable_q;
	logic tail_req;
	logic reset_req;
	logic ctrl_wr;
	logic wr_acc;
	logic rd_acc;
	logic hit;
	tefc_pkg::tefc_state_e state;

	// access decode; slave answers without wait
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign hit = (paddr == tefc_pkg::ADDR_CTRL) | (paddr == tefc_pkg::ADDR_STAT) |
		(paddr == tefc_pkg::ADDR_MASK) | (paddr == tefc_pkg::ADDR_MODE);
	assign pslverr = psel & penable & ~hit;
	// write access aimed at the control word
	assign ctrl_wr = wr_acc & (paddr == tefc_pkg::ADDR_CTRL);

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			tefc_pkg::ADDR_CTRL: next_prdata = {16'h0000, ctrl};
			tefc_pkg::ADDR_STAT: next_prdata = {28'h0000000, stat};
			tefc_pkg::ADDR_MASK: next_prdata = {28'h0000000, mask};
			tefc_pkg::ADDR_MODE: next_prdata = {29'h00000000, controller_operating_mode};
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	// read data registered in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operating mode register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			controller_operating_mode <= tefc_pkg::MODE_RESET;
		end else if (wr_acc && paddr == tefc_pkg::ADDR_MODE) begin
			controller_operating_mode <= pwdata[2:0];
		end
	end

	// control register: plain read/write interrupt enable bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable <= 4'h0;
		end else if (ctrl_wr) begin
			irq_enable <= pwdata[3:0];
		end
	end

	// RULE5: timestamp enable only in config mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_enable_q <= 1'b0;
		end else if (ctrl_wr && controller_operating_mode == tefc_pkg::MODE_CONFIG) begin
			ts_enable_q <= pwdata[tefc_pkg::BIT_TS_EN];
		end
	end

	// RULE4: timestamp enable drives the store path
	assign event_timestamp_enable = ts_enable_q;

	// RULE8: reserved bits tied to zero
	// control word as software reads it
	assign ctrl = {5'h00, reset_req, 1'b0, tail_req, 2'h0, ts_enable_q, 1'b0, irq_enable};

	////////////////////////////////////////////////////////////////////////
	// RULE3: tail advance sets, pulses once, clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tail_req <= 1'b0;
		end else begin
			tail_req <= ctrl_wr & pwdata[tefc_pkg::BIT_TAIL_ADV];
		end
	end

	// one tail step per set bit
	assign tail_step = tail_req;

	// RULE1: queue reset sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= tefc_pkg::TEFC_IDLE;
			rst_cnt <= 4'h0;
		end else begin
			case (state)
				tefc_pkg::TEFC_IDLE: begin
					if (ctrl_wr && pwdata[tefc_pkg::BIT_RESET_REQ]) begin
						state <= tefc_pkg::TEFC_CLEAR;
						rst_cnt <= tefc_pkg::RESET_CYCLES;
					end
				end
				tefc_pkg::TEFC_CLEAR: begin
					rst_cnt <= rst_cnt - 4'h1;
					if (rst_cnt == 4'h1) begin
						state <= tefc_pkg::TEFC_DONE;
					end
				end
				tefc_pkg::TEFC_DONE: state <= tefc_pkg::TEFC_IDLE;
				default: state <= tefc_pkg::TEFC_IDLE;
			endcase
		end
	end

	// request bit reads one until the reset has finished
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_req <= 1'b0;
		end else begin
			reset_req <= (state == tefc_pkg::TEFC_CLEAR) |
				(state == tefc_pkg::TEFC_IDLE && ctrl_wr && pwdata[tefc_pkg::BIT_RESET_REQ]);
		end
	end

	assign queue_clear = (state == tefc_pkg::TEFC_CLEAR);

	////////////////////////////////////////////////////////////////////////
	// event edges, one detector per source
	assign evt_level = {queue_overflow, queue_full, queue_half_full, queue_not_empty};
	genvar gi;
	generate
		for (gi = 0; gi < tefc_pkg::NUM_EVT; gi++) begin : g_evt
			tefc_edge u_edge (
				.pclk(pclk),
				.presetn(presetn),
				.level(evt_level[gi]),
				.rise(evt_rise[gi])
			);
			// RULE6: enable bit gates each event
			assign evt_gate[gi] = evt_rise[gi] & ctrl[gi];
		end
	endgenerate

	// sticky status, set wins over read clear
	// only bits captured in read data are cleared, so an event
	// landing between setup and access is not lost
	always_comb begin
		next_stat = stat;
		if (rd_acc && paddr == tefc_pkg::ADDR_STAT) begin
			next_stat = stat & ~prdata[3:0];
		end
		next_stat = next_stat | evt_gate;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= tefc_pkg::STAT_RESET;
		end else begin
			stat <= next_stat;
		end
	end

	// interrupt mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= tefc_pkg::MASK_RESET;
		end else if (wr_acc && paddr == tefc_pkg::ADDR_MASK) begin
			mask <= pwdata[3:0];
		end
	end

	// RULE7: full and others reach irq via enables
	// RULE9: half and not-empty gated by bits one and zero
	assign irq = |(stat & mask);

	////////////////////////////////////////////////////////////////////////
	// assertions
	reset_done_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		$rose(queue_clear) |-> queue_clear [*4] ##1 !queue_clear ##1 !ctrl[10])
		else $error("queue reset length wrong");
	tail_once_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		tail_step |=> !tail_step)
		else $error("tail advanced more than once");
	tail_cause_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		tail_step |-> $past(wr_acc) && $past(pwdata[8]))
		else $error("tail moved without request");
	ts_out_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		event_timestamp_enable == ctrl[5])
		else $error("timestamp output mismatch");
	ts_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		controller_operating_mode != 3'h4 |=> $stable(ctrl[5]))
		else $error("timestamp changed outside config");
	ovf_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		$rose(stat[3]) |-> $past(ctrl[3]))
		else $error("overflow flagged while disabled");
	full_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		$rose(stat[2]) |-> $past(ctrl[2]))
		else $error("full flagged while disabled");
	rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		(ctrl & 16'hFAD0) == 16'h0000)
		else $error("reserved control bit set");
	tail_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		ctrl_wr && pwdata[8] |=> tail_step)
		else $error("tail request not acted on");
	reset_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		state == tefc_pkg::TEFC_IDLE && !(ctrl_wr && pwdata[10]) |=> !queue_clear)
		else $error("queue cleared without request");
	ts_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		ctrl_wr && controller_operating_mode == 3'h4 |=> ctrl[5] == $past(pwdata[5]))
		else $error("timestamp write lost in config");
	stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		rd_acc && paddr == 12'h004 && evt_gate == 4'h0 |=> (stat & prdata[3:0]) == 4'h0)
		else $error("status not cleared by read");
	low_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		($rose(stat[1]) |-> $past(ctrl[1])) and ($rose(stat[0]) |-> $past(ctrl[0])))
		else $error("half or not-empty flagged while disabled");
	reset_cov: cover property (@(posedge pclk) disable iff (!presetn) $fell(queue_clear));
	tail_cov: cover property (@(posedge pclk) disable iff (!presetn) tail_step);
	irq_cov: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	ts_lock_cov: cover property (@(posedge pclk) disable iff (!presetn)
		ctrl_wr && controller_operating_mode != 3'h4);
endmodule // tefc_ctrl
`default_nettype wire

// *** design/tefc_pkg.sv ***
`default_nettype none
package tefc_pkg;
	// register byte addresses on the apb bus
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	localparam logic [11:0] ADDR_MASK = 12'h008;
	localparam logic [11:0] ADDR_MODE = 12'h00C;
	// control register field positions
	localparam int BIT_RESET_REQ = 10;
	localparam int BIT_TAIL_ADV = 8;
	localparam int BIT_TS_EN = 5;
	localparam int BIT_OVF_IE = 3;
	localparam int BIT_FULL_IE = 2;
	localparam int BIT_HALF_IE = 1;
	localparam int BIT_NE_IE = 0;
	// writable bits of the control register
	localparam logic [15:0] CTRL_RW_MASK = 16'h002F;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// operating mode encoding for configuration
	localparam logic [2:0] MODE_CONFIG = 3'h4;
	localparam logic [2:0] MODE_RESET = 3'h4;
	// status and mask layout: 0 ne, 1 half, 2 full, 3 ovf
	localparam int NUM_EVT = 4;
	localparam logic [3:0] STAT_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'hF;
	// cycles the queue reset takes
	localparam logic [3:0] RESET_CYCLES = 4'h4;
	typedef enum logic [1:0] {
		TEFC_IDLE = 2'b00,
		TEFC_CLEAR = 2'b01,
		TEFC_DONE = 2'b11
	} tefc_state_e;
endpackage : tefc_pkg
`default_nettype wire

// *** design/tefc_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
// rising-edge detector for event levels
module tefc_edge (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic level,
	output logic rise
);
	logic last;
	// previous sample of the level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= 1'b0;
		end else begin
			last <= level;
		end
	end
	assign rise = level & ~last;
endmodule // tefc_edge
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] ev = 4'h0;
	logic queue_clear;
	logic tail_step;
	logic ts_en;
	logic irq;
	logic [31:0] rd;
	logic last_err;
	logic [31:0] seed = 32'h000008F2;
	logic [63:0] e;
	logic [63:0] expq[$];
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	int tail_cnt = 0;
	int clr_cnt = 0;
	int t0;
	int n;
	////////////////////////////////////////////////////////////////
	// clock and device
	always #2.5 pclk = ~pclk;
	tefc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .queue_overflow(ev[3]), .queue_full(ev[2]),
		.queue_half_full(ev[1]), .queue_not_empty(ev[0]), .queue_clear(queue_clear),
		.tail_step(tail_step), .event_timestamp_enable(ts_en), .irq(irq));
	////////////////////////////////////////////////////////////////
	// compare, report, finish
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// apb transfer; a read with nonzero mask leaves a note for the monitor
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
		int w;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr && m != 32'h00000000) expq.push_back({m, d});
		@(posedge pclk);
		penable <= 1'b1;
		w = 0;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'b1 && w < 50);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev[i] <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task test_end(input int k);
		$display("test %0d done", k);
	endtask
	////////////////////////////////////////////////////////////////
	// read monitor, pulse counters, timeout
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && expq.size() > 0) begin
			e = expq.pop_front();
			check(prdata & e[63:32], e[31:0] & e[63:32]);
		end
	end
	always @(posedge pclk) begin
		tail_cnt <= tail_cnt + (tail_step === 1'b1 ? 1 : 0);
		clr_cnt <= clr_cnt + (queue_clear === 1'b1 ? 1 : 0);
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, tefc_pkg::ADDR_CTRL, 32'h00000000, 32'hFFFFFFFF);
		apb(1'b0, tefc_pkg::ADDR_STAT, 32'h00000000, 32'h0000000F);
		apb(1'b0, tefc_pkg::ADDR_MASK, 32'h0000000F, 32'h0000000F);
		apb(1'b0, tefc_pkg::ADDR_MODE, 32'h00000004, 32'h00000007);
		apb(1'b0, 12'h010, 32'h00000000, 32'hFFFFFFFF);
		check({31'h0, last_err}, 32'h00000001);
		test_end(1);
		apb(1'b1, tefc_pkg::ADDR_CTRL, 32'hFFFFFAFF, 32'h0);
		apb(1'b0, tefc_pkg::ADDR_CTRL, 32'h0000002F, 32'hFFFFFFFF);
		check({31'h0, ts_en}, 32'h00000001);
		apb(1'b1, tefc_pkg::ADDR_MODE, 32'h00000000, 32'h0);
		apb(1'b1, tefc_pkg::ADDR_CTRL, 32'h0000000F, 32'h0);
		apb(1'b0, tefc_pkg::ADDR_CTRL, 32'h0000002F, 32'hFFFFFFFF);
		check({31'h0, ts_en}, 32'h00000001);
		apb(1'b1, tefc_pkg::ADDR_MODE, 32'h00000004, 32'h0);
		apb(1'b1, tefc_pkg::ADDR_CTRL, 32'h0000000F, 32'h0);
		@(negedge pclk);
		check({31'h0, ts_en}, 32'h00000000);
		test_end(2);
		t0 = tail_cnt;
		apb(1'b1, tefc_pkg::ADDR_CTRL, 32'h0000010F, 32'h0);
		apb(1'b1, tefc_pkg::ADDR_CTRL, 32'h0000000F, 32'h0);
		repeat (4) @(posedge pclk);
		check(32'(tail_cnt - t0), 32'h00000001);
		t0 = clr_cnt;
		apb(1'b1, tefc_pkg::ADDR_CTRL, 32'h0000040F, 32'h0);
		n = 0;
		do begin
			apb(1'b0, tefc_pkg::ADDR_CTRL, 32'h0, 32'h0);
			n++;
		end while (rd[10] !== 1'b0 && n < 20);
		check(32'(clr_cnt - t0), 32'h00000004);
		check(rd, 32'h0000000F);
		test_end(3);
		// random mask values, low four bits kept
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			apb(1'b1, tefc_pkg::ADDR_MASK, seed, 32'h0);
			apb(1'b0, tefc_pkg::ADDR_MASK, seed & 32'h0000000F, 32'hFFFFFFFF);
		end
		apb(1'b1, tefc_pkg::ADDR_MASK, 32'h00000000, 32'h0);
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			check({31'h0, irq}, 32'h00000000);
			apb(1'b0, tefc_pkg::ADDR_STAT, 32'h1 << i, 32'h0000000F);
			apb(1'b0, tefc_pkg::ADDR_STAT, 32'h0, 32'h0000000F);
		end
		apb(1'b1, tefc_pkg::ADDR_MASK, 32'h0000000F, 32'h0);
		pulse(3);
		check({31'h0, irq}, 32'h00000001);
		apb(1'b0, tefc_pkg::ADDR_STAT, 32'h00000008, 32'h0000000F);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h00000000);
		pulse(2);
		check({31'h0, irq}, 32'h00000001);
		apb(1'b0, tefc_pkg::ADDR_STAT, 32'h00000004, 32'h0000000F);
		test_end(4);
		apb(1'b1, tefc_pkg::ADDR_CTRL, 32'h00000000, 32'h0);
		for (int i = 0; i < 4; i++) pulse(i);
		apb(1'b0, tefc_pkg::ADDR_STAT, 32'h0, 32'h0000000F);
		check({31'h0, irq}, 32'h00000000);
		test_end(5);
		complete_run;
	end
endmodule // tb_top
`default_nettype wire
